// ### include/ttb_pkg.sv
// Constants, register map and carrier types of the trip threshold bank.
// Assumes a 32-bit AXI4-Lite register bus and a converter on the same clock.
package ttb_pkg;
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_TEMP = 8'h00;
    localparam logic [7:0] OFS_UPPER = 8'h04;
    localparam logic [7:0] OFS_LOWER = 8'h08;
    localparam logic [7:0] OFS_CRIT = 8'h0C;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic [7:0] OFS_IRQ_STS = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
    localparam int WORD_LSB = 2;
    localparam logic [15:0] THR_KEEP = 16'h1FFC;
    localparam logic [15:0] THR_RESET = 16'h0000;
    localparam int THR_MSB = 12;
    localparam int THR_LSB = 2;
    localparam int TEMP_W = 12;
    localparam int CMP_W = 11;
    localparam int CFG_LOCK = 0;
    localparam int CFG_CRIT_ONLY = 1;
    localparam int CFG_EVT_EN = 2;
    localparam int CFG_HYS_LO = 4;
    localparam int TRIP_N = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [11:0] HYS_0 = 12'h000;
    localparam logic [11:0] HYS_1P5 = 12'h006;
    localparam logic [11:0] HYS_3 = 12'h00C;
    localparam logic [11:0] HYS_6 = 12'h018;
    typedef struct packed {
        logic crit;
        logic above;
        logic below;
    } ttb_trip_t;
    typedef struct packed {
        logic [1:0] hys;
        logic evt_en;
        logic crit_only;
        logic lock;
    } ttb_cfg_t;
    // Hysteresis in steps of 0.25 degrees, the threshold's own LSB.
    function automatic logic [11:0] hys_steps(input logic [1:0] sel);
        unique case (sel)
            2'h0: hys_steps = HYS_0;
            2'h1: hys_steps = HYS_1P5;
            2'h2: hys_steps = HYS_3;
            2'h3: hys_steps = HYS_6;
        endcase
    endfunction
endpackage

// ### hw/ttb_trip_cmp.sv
// One trip status bit with hysteresis against one programmed limit.
// Assumes temperature and limit are aligned two's complement at 0.25 degree steps.
`timescale 1ns/100ps
`default_nettype none
module ttb_trip_cmp #(
    parameter bit FALLING = 1'b0,
    parameter int W = 11
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] temp,
    input wire logic [W-1:0] lim,
    input wire logic [W:0] hys,
    output logic trip
);
    logic signed [W:0] t_x;
    logic signed [W:0] lim_x;
    logic signed [W:0] low_x;
    logic at_lim;
    logic under;
    logic trip_ff;

    // One extra bit keeps limit minus hysteresis from wrapping at the cold end.
    assign t_x = $signed({temp[W-1], temp});
    assign lim_x = $signed({lim[W-1], lim});
    assign low_x = lim_x - $signed(hys);
    assign at_lim = t_x >= lim_x;
    assign under = t_x < low_x;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trip_ff <= 1'b0;
        end else if (FALLING) begin
            if (under) begin
                trip_ff <= 1'b1;
            end else if (at_lim) begin
                trip_ff <= 1'b0;
            end
        end else begin
            if (at_lim) begin
                trip_ff <= 1'b1;
            end else if (under) begin
                trip_ff <= 1'b0;
            end
        end
    end
    assign trip = trip_ff;

    a_trip_sets: assert property (@(posedge core_clk) disable iff (rst)
        (FALLING ? under : at_lim) |=> trip)
        else $error("Trip bit did not set past its limit.");
    a_trip_clears: assert property (@(posedge core_clk) disable iff (rst)
        (FALLING ? at_lim : under) |=> !trip)
        else $error("Trip bit did not clear past its hysteresis.");
endmodule
`default_nettype wire

// ### hw/ttb_irq.sv
// Sticky event status with write-one-to-clear and an enable mask.
// Assumes event pulses and clear writes arrive on core_clk.
`timescale 1ns/100ps
`default_nettype none
module ttb_irq #(
    parameter int N = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [N-1:0] ev,
    input wire logic clr_we,
    input wire logic [N-1:0] clr,
    input wire logic [N-1:0] en,
    output logic [N-1:0] sts,
    output logic irq
);
    logic [N-1:0] sts_ff;

    // A new event in the clear cycle survives, so no edge is lost.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sts_ff <= '0;
        end else begin
            sts_ff <= (sts_ff & ~(clr_we ? clr : '0)) | ev;
        end
    end
    assign sts = sts_ff;
    assign irq = |(sts_ff & en);

    a_set_wins: assert property (@(posedge core_clk) disable iff (rst)
        (|ev) |=> ((sts & $past(ev)) == $past(ev)))
        else $error("Event lost in status register.");
    a_clear_acts: assert property (@(posedge core_clk) disable iff (rst)
        clr_we && ((clr & ~ev) != '0) |=> ((sts & $past(clr & ~ev)) == '0))
        else $error("Status bit not cleared.");
endmodule
`default_nettype wire

// ### hw/ttb_bank.sv
// Temperature word and trip threshold bank behind an AXI4-Lite slave.
// Assumes the converter delivers its reading on core_clk, bits 12 to 1 of the word.
`timescale 1ns/100ps
`default_nettype none
module ttb_bank (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ttb_pkg::TEMP_W-1:0] temp_meas,
    input wire logic [ttb_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ttb_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic event_out,
    output logic irq
);
    localparam int AW = ttb_pkg::AXI_AW;

    logic [AW-1:0] awaddr_ff;
    logic aw_held_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_held_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [ttb_pkg::TEMP_W-1:0] temp_ff;
    logic [15:0] upper_window_limit_ff;
    logic [15:0] lower_window_limit_ff;
    logic [15:0] critical_limit_ff;
    ttb_pkg::ttb_cfg_t cfg_ff;
    logic [ttb_pkg::TRIP_N-1:0] irq_en_ff;
    ttb_pkg::ttb_trip_t trip;
    ttb_pkg::ttb_trip_t trip_d_ff;
    logic event_ff;
    logic do_write;
    logic do_read;
    logic [15:0] temp_word;
    logic [ttb_pkg::CMP_W-1:0] temp_cmp;
    logic [ttb_pkg::CMP_W:0] hys;
    logic [ttb_pkg::TRIP_N-1:0] irq_sts;
    logic [ttb_pkg::TRIP_N-1:0] trip_rise;
    logic [15:0] nxt_upper;
    logic [15:0] nxt_lower;
    logic [15:0] nxt_crit;

    function automatic logic hit(input logic [AW-1:0] addr, input logic [7:0] ofs);
        hit = addr[AW-1:ttb_pkg::WORD_LSB] == ofs[AW-1:ttb_pkg::WORD_LSB];
    endfunction

    function automatic logic mapped(input logic [AW-1:0] addr);
        mapped = hit(addr, ttb_pkg::OFS_TEMP) || hit(addr, ttb_pkg::OFS_UPPER)
            || hit(addr, ttb_pkg::OFS_LOWER) || hit(addr, ttb_pkg::OFS_CRIT)
            || hit(addr, ttb_pkg::OFS_CFG) || hit(addr, ttb_pkg::OFS_IRQ_STS)
            || hit(addr, ttb_pkg::OFS_IRQ_CLR) || hit(addr, ttb_pkg::OFS_IRQ_EN);
    endfunction

    // Byte-lane merge; reserved positions are dropped by the mask afterwards.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

    // Write address and data are held separately so either may come first.
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            w_held_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= ttb_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= mapped(awaddr_ff) ? ttb_pkg::RESP_OKAY : ttb_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    assign nxt_upper = merge16(upper_window_limit_ff, wdata_ff, wstrb_ff) & ttb_pkg::THR_KEEP;
    assign nxt_lower = merge16(lower_window_limit_ff, wdata_ff, wstrb_ff) & ttb_pkg::THR_KEEP;
    assign nxt_crit = merge16(critical_limit_ff, wdata_ff, wstrb_ff) & ttb_pkg::THR_KEEP;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            upper_window_limit_ff <= ttb_pkg::THR_RESET;
            lower_window_limit_ff <= ttb_pkg::THR_RESET;
            critical_limit_ff <= ttb_pkg::THR_RESET;
        end else if (do_write) begin
            // Locked window writes still answer OKAY; the value simply stays.
            if (hit(awaddr_ff, ttb_pkg::OFS_UPPER) && !cfg_ff.lock) begin
                upper_window_limit_ff <= nxt_upper;
            end
            if (hit(awaddr_ff, ttb_pkg::OFS_LOWER) && !cfg_ff.lock) begin
                lower_window_limit_ff <= nxt_lower;
            end
            if (hit(awaddr_ff, ttb_pkg::OFS_CRIT)) begin
                critical_limit_ff <= nxt_crit;
            end
        end
    end

    // The lock only ever sets; nothing but reset releases it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= '0;
        end else if (do_write && hit(awaddr_ff, ttb_pkg::OFS_CFG) && wstrb_ff[0]) begin
            if (wdata_ff[ttb_pkg::CFG_LOCK]) begin
                cfg_ff.lock <= 1'b1;
            end
            if (!cfg_ff.lock) begin
                cfg_ff.crit_only <= wdata_ff[ttb_pkg::CFG_CRIT_ONLY];
                cfg_ff.evt_en <= wdata_ff[ttb_pkg::CFG_EVT_EN];
            end
            cfg_ff.hys <= wdata_ff[ttb_pkg::CFG_HYS_LO +: 2];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_en_ff <= '0;
        end else if (do_write && hit(awaddr_ff, ttb_pkg::OFS_IRQ_EN) && wstrb_ff[0]) begin
            irq_en_ff <= wdata_ff[ttb_pkg::TRIP_N-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            temp_ff <= '0;
        end else begin
            temp_ff <= temp_meas;
        end
    end

    // Status, sign, magnitude down to 0.125, then a constant zero.
    assign temp_word = {trip, temp_ff, 1'b0};

    // Only the 0.25 degree grid takes part, so the finest bit cannot toggle a trip.
    assign temp_cmp = temp_ff[ttb_pkg::TEMP_W-1:1];
    assign hys = ttb_pkg::hys_steps(cfg_ff.hys);

    ttb_trip_cmp #(
        .FALLING(1'b0),
        .W(ttb_pkg::CMP_W)
    ) u_crit (
        .core_clk(core_clk),
        .rst(rst),
        .temp(temp_cmp),
        .lim(critical_limit_ff[ttb_pkg::THR_MSB:ttb_pkg::THR_LSB]),
        .hys(hys),
        .trip(trip.crit)
    );

    ttb_trip_cmp #(
        .FALLING(1'b0),
        .W(ttb_pkg::CMP_W)
    ) u_above (
        .core_clk(core_clk),
        .rst(rst),
        .temp(temp_cmp),
        .lim(upper_window_limit_ff[ttb_pkg::THR_MSB:ttb_pkg::THR_LSB]),
        .hys(hys),
        .trip(trip.above)
    );

    ttb_trip_cmp #(
        .FALLING(1'b1),
        .W(ttb_pkg::CMP_W)
    ) u_below (
        .core_clk(core_clk),
        .rst(rst),
        .temp(temp_cmp),
        .lim(lower_window_limit_ff[ttb_pkg::THR_MSB:ttb_pkg::THR_LSB]),
        .hys(hys),
        .trip(trip.below)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trip_d_ff <= '0;
        end else begin
            trip_d_ff <= trip;
        end
    end
    assign trip_rise = trip & ~trip_d_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            event_ff <= 1'b0;
        end else if (cfg_ff.crit_only) begin
            event_ff <= cfg_ff.evt_en && trip.crit;
        end else begin
            event_ff <= cfg_ff.evt_en && (|trip);
        end
    end
    assign event_out = event_ff;

    ttb_irq #(
        .N(ttb_pkg::TRIP_N)
    ) u_irq (
        .core_clk(core_clk),
        .rst(rst),
        .ev(trip_rise),
        .clr_we(do_write && hit(awaddr_ff, ttb_pkg::OFS_IRQ_CLR) && wstrb_ff[0]),
        .clr(wdata_ff[ttb_pkg::TRIP_N-1:0]),
        .en(irq_en_ff),
        .sts(irq_sts),
        .irq(irq)
    );

    assign s_axi_arready = !rvalid_ff;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= ttb_pkg::RESP_OKAY;
            rdata_ff <= '0;
        end else if (do_read) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= mapped(s_axi_araddr) ? ttb_pkg::RESP_OKAY : ttb_pkg::RESP_SLVERR;
            if (hit(s_axi_araddr, ttb_pkg::OFS_TEMP)) begin
                rdata_ff <= {16'h0000, temp_word};
            end else if (hit(s_axi_araddr, ttb_pkg::OFS_UPPER)) begin
                rdata_ff <= {16'h0000, upper_window_limit_ff};
            end else if (hit(s_axi_araddr, ttb_pkg::OFS_LOWER)) begin
                rdata_ff <= {16'h0000, lower_window_limit_ff};
            end else if (hit(s_axi_araddr, ttb_pkg::OFS_CRIT)) begin
                rdata_ff <= {16'h0000, critical_limit_ff};
            end else if (hit(s_axi_araddr, ttb_pkg::OFS_CFG)) begin
                rdata_ff <= {26'h0, cfg_ff.hys, 1'b0, cfg_ff.evt_en, cfg_ff.crit_only, cfg_ff.lock};
            end else if (hit(s_axi_araddr, ttb_pkg::OFS_IRQ_STS)) begin
                rdata_ff <= {29'h0, irq_sts};
            end else if (hit(s_axi_araddr, ttb_pkg::OFS_IRQ_EN)) begin
                rdata_ff <= {29'h0, irq_en_ff};
            end else begin
                rdata_ff <= '0;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    sequence s_upper_write_locked;
        do_write && hit(awaddr_ff, ttb_pkg::OFS_UPPER) && cfg_ff.lock;
    endsequence
    sequence s_lower_write_locked;
        do_write && hit(awaddr_ff, ttb_pkg::OFS_LOWER) && cfg_ff.lock;
    endsequence

    a_upper_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
        s_upper_write_locked |=> $stable(upper_window_limit_ff))
        else $error("Locked upper limit changed.");
    a_lower_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
        s_lower_write_locked |=> $stable(lower_window_limit_ff))
        else $error("Locked lower limit changed.");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        ((upper_window_limit_ff | lower_window_limit_ff | critical_limit_ff) & ~ttb_pkg::THR_KEEP) == '0)
        else $error("Reserved limit bit is set.");
    a_crit_write_lands: assert property (@(posedge core_clk) disable iff (rst)
        do_write && hit(awaddr_ff, ttb_pkg::OFS_CRIT) |=> critical_limit_ff == $past(nxt_crit))
        else $error("Critical limit write did not land.");
    a_temp_read_word: assert property (@(posedge core_clk) disable iff (rst)
        do_read && hit(s_axi_araddr, ttb_pkg::OFS_TEMP)
        |=> s_axi_rvalid && s_axi_rdata[15:0] == {$past(trip), $past(temp_ff), 1'b0})
        else $error("Temperature word read wrong.");
    a_crit_only_event: assert property (@(posedge core_clk) disable iff (rst)
        cfg_ff.crit_only && cfg_ff.evt_en |=> event_out == $past(trip.crit))
        else $error("Critical-only event wrong.");
    a_write_answer: assert property (@(posedge core_clk) disable iff (rst)
        do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("Write response missing.");
endmodule
`default_nettype wire

// ### bench/ttb_host_model.sv
// Host controller model: drives the register bus as its master.
// Assumes callers enter its tasks just after a rising core_clk edge.
`timescale 1ns/100ps
`default_nettype none
module ttb_host_model (
    input wire logic core_clk,
    output logic [ttb_pkg::AXI_AW-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ttb_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    end

    // Released payload is inverted so a slave that samples late sees garbage, not the old value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'h0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'h0;
                s_axi_wdata <= ~d;
            end
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'h0;
                s_axi_araddr <= ~a;
            end
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // Limit changes are made with interrupts masked; the caller unmasks once settled.
    task automatic lim(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(ttb_pkg::OFS_IRQ_EN, 32'h0, r);
        wr(a, d, r);
    endtask
endmodule
`default_nettype wire

// ### bench/ttb_bank_tb.sv
// Self-checking bench for the trip threshold bank.
// Assumes the host model as bus master and a converter reading driven here.
`timescale 1ns/100ps
`default_nettype none
module ttb_bank_tb;
    logic core_clk;
    logic rst;
    logic [11:0] temp_meas;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, event_out, irq;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    ttb_bank i_dut (.*);
    ttb_host_model i_host (.*);

    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("errors %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        i_host.rd(a, d, r);
        chk("rresp", {30'h0, r}, {30'h0, ttb_pkg::RESP_OKAY});
        chk("rdata", d, e);
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        i_host.wr(a, d, r);
        chk("bresp", {30'h0, r}, {30'h0, ttb_pkg::RESP_OKAY});
    endtask

    // Waits out the three-stage path from converter to status.
    task automatic st(input logic [11:0] t);
        @(posedge core_clk);
        temp_meas <= t;
        repeat (4) @(posedge core_clk);
    endtask

    function automatic logic [31:0] tw(input logic [2:0] s, input logic [11:0] t);
        return {16'h0, s, t, 1'h0};
    endfunction

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] a;
        rst = 1'h1;
        temp_meas = 12'h000;
        repeat (6) @(posedge core_clk);
        rst <= 1'h0;
        rc(ttb_pkg::OFS_TEMP, tw(3'h6, 12'h000));
        i_host.rd(8'h20, d, r);
        chk("rresp", {30'h0, r}, {30'h0, ttb_pkg::RESP_SLVERR});
        chk("rdata", d, 32'h0);
        i_host.wr(8'h20, 32'hFFFF, r);
        chk("bresp", {30'h0, r}, {30'h0, ttb_pkg::RESP_SLVERR});
        for (int i = 0; i < 3; i++) begin
            a = ttb_pkg::OFS_UPPER + 8'(4 * i);
            rc(a, 32'h0);
            i_host.lim(a, 32'hFFFF);
            rc(a, 32'h1FFC);
        end
        i_host.lim(ttb_pkg::OFS_CRIT, 32'h07D0);
        i_host.lim(ttb_pkg::OFS_UPPER, 32'h07C0);
        i_host.lim(ttb_pkg::OFS_LOWER, 32'h1C90);
        st(12'h0CE);
        rc(ttb_pkg::OFS_TEMP, 32'h019C);
        st(12'hF32);
        rc(ttb_pkg::OFS_TEMP, 32'h1E64);
        st(12'h3E8);
        rc(ttb_pkg::OFS_TEMP, 32'hC7D0);
        i_host.lim(ttb_pkg::OFS_LOWER, 32'h07F0);
        rc(ttb_pkg::OFS_TEMP, 32'hE7D0);
        w(ttb_pkg::OFS_TEMP, 32'hFFFF);
        rc(ttb_pkg::OFS_TEMP, 32'hE7D0);
        st(12'h001);
        rc(ttb_pkg::OFS_TEMP, 32'h2002);
        w(ttb_pkg::OFS_CFG, 32'h10);
        i_host.lim(ttb_pkg::OFS_CRIT, 32'h0640);
        st(12'h320);
        rc(ttb_pkg::OFS_TEMP, tw(3'h5, 12'h320));
        st(12'h316);
        rc(ttb_pkg::OFS_TEMP, tw(3'h5, 12'h316));
        st(12'h312);
        rc(ttb_pkg::OFS_TEMP, tw(3'h1, 12'h312));
        i_host.lim(ttb_pkg::OFS_LOWER, 32'h0000);
        st(12'hFF6);
        rc(ttb_pkg::OFS_TEMP, tw(3'h0, 12'hFF6));
        st(12'hFF2);
        rc(ttb_pkg::OFS_TEMP, tw(3'h1, 12'hFF2));
        st(12'hFFE);
        rc(ttb_pkg::OFS_TEMP, tw(3'h1, 12'hFFE));
        st(12'h000);
        rc(ttb_pkg::OFS_TEMP, tw(3'h0, 12'h000));
        i_host.lim(ttb_pkg::OFS_UPPER, 32'h0100);
        w(ttb_pkg::OFS_CFG, 32'h14);
        st(12'h0A0);
        chk("event_out", {31'h0, event_out}, 32'h1);
        w(ttb_pkg::OFS_CFG, 32'h16);
        st(12'h0A0);
        chk("event_out", {31'h0, event_out}, 32'h0);
        rc(ttb_pkg::OFS_IRQ_STS, 32'h7);
        w(ttb_pkg::OFS_IRQ_CLR, 32'h7);
        rc(ttb_pkg::OFS_IRQ_STS, 32'h0);
        w(ttb_pkg::OFS_IRQ_EN, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        st(12'h070);
        st(12'h0A0);
        rc(ttb_pkg::OFS_IRQ_STS, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        w(ttb_pkg::OFS_IRQ_EN, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        w(ttb_pkg::OFS_IRQ_EN, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        w(ttb_pkg::OFS_IRQ_CLR, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        rc(ttb_pkg::OFS_IRQ_STS, 32'h0);
        w(ttb_pkg::OFS_CFG, 32'h17);
        rc(ttb_pkg::OFS_CFG, 32'h17);
        i_host.lim(ttb_pkg::OFS_UPPER, 32'h0200);
        rc(ttb_pkg::OFS_UPPER, 32'h0100);
        i_host.lim(ttb_pkg::OFS_LOWER, 32'h0200);
        rc(ttb_pkg::OFS_LOWER, 32'h0000);
        i_host.lim(ttb_pkg::OFS_CRIT, 32'h0300);
        rc(ttb_pkg::OFS_CRIT, 32'h0300);
        give_verdict();
    end
endmodule
`default_nettype wire
